// *** rtl/optical_module_control_status.sv ***
`timescale 1ns/1ps
`include "optmod_defines.svh"
module optical_module_control_status #(
   parameter int ON_CNT   = `ON_CYCLES,
   parameter int INIT_CNT = `INIT_CYCLES,
   parameter logic CAL_EXTERNAL = 1'b0,
   parameter logic [7:0] ID_BYTE = 8'h5a  // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   // Host pins
   input  wire logic        i_transmitter_off_in,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_out,
   output logic             o_sda_oe_n,
   output logic             o_present_out,
   output logic             o_present_oe_n,
   output logic             o_fault_out,
   output logic             o_fault_oe_n,
   output logic             o_signal_lost_out,
   output logic             o_signal_lost_oe_n,
   // Analog front end
   input  wire logic        i_laser_fault,
   input  wire logic        i_rx_lost,
   input  wire logic [15:0] i_temp,
   input  wire logic [15:0] i_vcc,
   input  wire logic [15:0] i_bias,
   input  wire logic [15:0] i_txp,
   input  wire logic [15:0] i_rxp,
   output logic             o_laser_on,
   output logic             o_cal_external
);
   localparam int OFF_CNT  = `OFF_CYCLES;
   localparam int RST_CNT  = `RESET_CYCLES;
   localparam int FLT_CNT  = `FAULT_CYCLES;
   localparam int LOSS_CNT = `LOSS_CYCLES;
   logic [1:0] off_s_r, flt_s_r, los_s_r, scl_s_r, sda_s_r;
   logic off_w, flt_w, los_w;
   optmod_pkg::tx_state_t st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic laser_r, laser_nxt, fault_r, fault_nxt;
   logic los_r, los_nxt;
   logic [15:0] diag_r [5];
   logic [15:0] diag_in_w [5];
   logic page_w;
   logic [7:0] off_w8, rdata_w;
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         off_s_r <= 2'b11; flt_s_r <= 2'b00; los_s_r <= 2'b11;
         scl_s_r <= 2'b11; sda_s_r <= 2'b11;
      end else begin
         off_s_r <= {off_s_r[0], i_transmitter_off_in};
         flt_s_r <= {flt_s_r[0], i_laser_fault};
         los_s_r <= {los_s_r[0], i_rx_lost};
         scl_s_r <= {scl_s_r[0], i_scl};
         sda_s_r <= {sda_s_r[0], i_sda};
      end
   end
   assign off_w = off_s_r[1];
   assign flt_w = flt_s_r[1];
   assign los_w = los_s_r[1];
   // Transmitter control
   always_comb begin
      st_nxt = st_r; cnt_nxt = cnt_r; laser_nxt = 1'b0; fault_nxt = fault_r;
      case (st_r)
         optmod_pkg::TX_INIT: begin
            fault_nxt = 1'b0;
            if (cnt_r >= 32'(INIT_CNT - 1)) begin
               st_nxt = off_w ? optmod_pkg::TX_OFF : optmod_pkg::TX_ON;
               cnt_nxt = 32'h0;
            end else cnt_nxt = cnt_r + 32'h1;
         end
         optmod_pkg::TX_ON: begin
            if (off_w) begin
               st_nxt = optmod_pkg::TX_OFF; cnt_nxt = 32'h0;
            end else if (flt_w) begin
               st_nxt = optmod_pkg::TX_FAULT; cnt_nxt = 32'h0;
            end else begin
               laser_nxt = (cnt_r >= 32'(ON_CNT / 2));
               if (!laser_nxt) cnt_nxt = cnt_r + 32'h1;
            end
         end
         optmod_pkg::TX_OFF: begin
            if (!off_w) begin
               st_nxt = optmod_pkg::TX_ON; cnt_nxt = 32'h0;
            end
         end
         optmod_pkg::TX_FAULT: begin
            fault_nxt = 1'b1;
            if (off_w) begin
               if (cnt_r >= 32'(RST_CNT - 1)) begin
                  fault_nxt = 1'b0; st_nxt = optmod_pkg::TX_OFF;
                  cnt_nxt = 32'h0;
               end else cnt_nxt = cnt_r + 32'h1;
            end else cnt_nxt = 32'h0;
         end
         default: st_nxt = optmod_pkg::TX_INIT;
      endcase
   end
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         st_r <= optmod_pkg::TX_INIT; cnt_r <= 32'h0;
         laser_r <= 1'b0; fault_r <= 1'b0;
      end else begin
         st_r <= st_nxt; cnt_r <= cnt_nxt;
         laser_r <= laser_nxt; fault_r <= fault_nxt;
      end
   end
   always_comb los_nxt = los_w;
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) los_r <= 1'b1;
      else los_r <= los_nxt;
   end
   assign diag_in_w[0] = i_temp;
   assign diag_in_w[1] = i_vcc;
   assign diag_in_w[2] = i_bias;
   assign diag_in_w[3] = i_txp;
   assign diag_in_w[4] = i_rxp;
   for (genvar g = 0; g < 5; g++) begin : g_diag
      always_ff @(posedge i_clock or posedge i_reset) begin
         if (i_reset) diag_r[g] <= 16'h0000;
         else diag_r[g] <= diag_in_w[g];
      end
   end
   always_comb begin
      rdata_w = 8'h00;
      if (!page_w) begin
         if (off_w8 == 8'h00) rdata_w = ID_BYTE;
         else if (off_w8 == `CAL_OFF)
            rdata_w = CAL_EXTERNAL ? `CAL_EXT_CODE : `CAL_INT_CODE;
      end else if (off_w8 >= `DIAG_TEMP && off_w8 < `DIAG_END) begin
         rdata_w = off_w8[0] ? diag_r[3'((off_w8 - `DIAG_TEMP) >> 1)][7:0]
                             : diag_r[3'((off_w8 - `DIAG_TEMP) >> 1)][15:8];
      end
   end
   mgmt_target u_mgmt (
      .i_clock    (i_clock),
      .i_reset    (i_reset),
      .i_scl      (scl_s_r[1]),
      .i_sda      (sda_s_r[1]),
      .o_sda_out  (o_sda_out),
      .o_sda_oe_n (o_sda_oe_n),
      .o_page     (page_w),
      .o_offset   (off_w8),
      .i_rdata    (rdata_w)
   );
   assign o_present_out = 1'b0;
   assign o_present_oe_n = 1'b0;
   assign o_fault_out = 1'b0;
   assign o_fault_oe_n = fault_r;
   assign o_signal_lost_out = 1'b0;
   assign o_signal_lost_oe_n = los_r;
   assign o_laser_on = laser_r;
   assign o_cal_external = CAL_EXTERNAL;

   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   sequence off_held_s;
      off_w [*3];
   endsequence
   sequence fault_seen_s;
      st_r == optmod_pkg::TX_ON && !off_w && flt_w;
   endsequence
   shut_off_a: assert property (off_w |-> ##[1:2] !o_laser_on)
      else $error("laser not extinguished");
   laser_gate_a: assert property (off_held_s |-> !o_laser_on)
      else $error("laser on while disabled");
   fault_set_a: assert property (fault_seen_s |-> ##2 o_fault_oe_n)
      else $error("fault not flagged");
   fault_pin_a: assert property (
      !o_fault_out && o_fault_oe_n == fault_r)
      else $error("fault pin mismatch");
   fault_hold_a: assert property (
      o_fault_oe_n && !off_w |=> o_fault_oe_n)
      else $error("fault dropped without shut-off");
   los_track_a: assert property (
      $changed(los_w) |=> o_signal_lost_oe_n == $past(los_w))
      else $error("loss output late");
   init_clear_a: assert property (
      st_r == optmod_pkg::TX_INIT |=> !o_fault_oe_n)
      else $error("fault set in init");
   present_a: assert property (!o_present_oe_n && !o_present_out)
      else $error("presence not grounded");
   laser_source_a: assert property (
      o_laser_on |-> $past(st_r) == optmod_pkg::TX_ON)
      else $error("laser on outside on state");
   on_bound_a: assert property (
      (st_r == optmod_pkg::TX_ON && laser_r && !off_w && !flt_w)
      |=> laser_r || $past(off_w) || $past(flt_w) || off_w || flt_w)
      else $error("laser dropped");
endmodule

// *** shared/optmod_defines.svh ***
// Contract
// - Optical output restored within 1 ms after shut-off input released.
// - Output off within 10 us of shut-off; 10 us shut-off clears fault.
// - Initialization, clearing fault indication, completes within 300 ms.
// - Fault indication asserted within 100 us of detected laser fault.
// - Fault output 0 normally, 1 on fault, driven open-collector.
// - Signal-lost output follows lost signal, changes within 100 us.
// - Shut-off input high or open disables transmitter, low enables it.
// - Management interface works at serial clock up to 400 kHz.
// - Presence line tied to ground to show module inserted.
// - Second definition line is serial clock, driven by host master.
// - Third definition line carries bidirectional serial data.
// - Identification memory and live diagnostics readable over serial port.
// - Report rx power, tx power, bias, supply voltage, temperature.
// - Internal or external calibrated diagnostics both supported.
`ifndef OPTMOD_DEFINES_SVH
`define OPTMOD_DEFINES_SVH
`define CLK_MHZ          50
`define T_ON_MS          1
`define T_OFF_US         10
`define T_INIT_MS        300
`define T_FAULT_US       100
`define T_RESET_US       10
`define T_LOSS_US        100
`define F_SCL_KHZ        400
`define ON_CYCLES        (`T_ON_MS * 1000 * `CLK_MHZ)
`define OFF_CYCLES       (`T_OFF_US * `CLK_MHZ)
`define INIT_CYCLES      (`T_INIT_MS * 1000 * `CLK_MHZ)
`define FAULT_CYCLES     (`T_FAULT_US * `CLK_MHZ)
`define RESET_CYCLES     (`T_RESET_US * `CLK_MHZ)
`define LOSS_CYCLES      (`T_LOSS_US * `CLK_MHZ)
`define ID_ADDR          7'h50
`define DIAG_ADDR        7'h51
`define DIAG_TEMP        8'h60
`define DIAG_VCC         8'h62
`define DIAG_BIAS        8'h64
`define DIAG_TXP         8'h66
`define DIAG_RXP         8'h68
`define DIAG_END         8'h6a
`define CAL_OFF          8'h5c
`define CAL_INT_CODE     8'h20
`define CAL_EXT_CODE     8'h10
`endif

// *** shared/optmod_pkg.sv ***
package optmod_pkg;
   typedef enum logic [3:0] {
      TX_INIT  = 4'h1,
      TX_ON    = 4'h2,
      TX_OFF   = 4'h4,
      TX_FAULT = 4'h8
   } tx_state_t;
   typedef enum logic [4:0] {
      I_IDLE = 5'h01,
      I_ADDR = 5'h02,
      I_ACK  = 5'h04,
      I_WR   = 5'h08,
      I_RD   = 5'h10
   } i2c_state_t;
endpackage

// *** rtl/mgmt_target.sv ***
`timescale 1ns/1ps
`include "optmod_defines.svh"
module mgmt_target (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   // Synchronised serial lines
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   // Data line drive, low enable pulls low
   output logic             o_sda_out,
   output logic             o_sda_oe_n,
   // Memory read port
   output logic             o_page,
   output logic [7:0]       o_offset,
   input  wire logic [7:0]  i_rdata
);
   logic scl_d_r, sda_d_r;
   logic start_w, stop_w, rise_w, fall_w;
   optmod_pkg::i2c_state_t st_r, st_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic       rd_r, rd_nxt, pg_r, pg_nxt, first_r, first_nxt;
   logic [7:0] off_r, off_nxt;
   logic       drv_r, drv_nxt;
   assign start_w = scl_d_r && i_scl && sda_d_r && !i_sda;
   assign stop_w  = scl_d_r && i_scl && !sda_d_r && i_sda;
   assign rise_w  = !scl_d_r && i_scl;
   assign fall_w  = scl_d_r && !i_scl;
   assign o_page  = pg_r;
   assign o_offset = off_r;
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = !drv_r;
   always_comb begin
      st_nxt = st_r; sh_nxt = sh_r; cnt_nxt = cnt_r; rd_nxt = rd_r;
      pg_nxt = pg_r; off_nxt = off_r; drv_nxt = drv_r; first_nxt = first_r;
      if (start_w) begin
         st_nxt = optmod_pkg::I_ADDR; cnt_nxt = 4'h0; drv_nxt = 1'b0;
      end else if (stop_w) begin
         st_nxt = optmod_pkg::I_IDLE; drv_nxt = 1'b0;
      end else begin
         case (st_r)
            optmod_pkg::I_IDLE: drv_nxt = 1'b0;
            optmod_pkg::I_ADDR, optmod_pkg::I_WR: begin
               if (rise_w) begin
                  sh_nxt = {sh_r[6:0], i_sda};
                  cnt_nxt = cnt_r + 4'h1;
               end
               if (fall_w && cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  if (st_r == optmod_pkg::I_ADDR) begin
                     if (sh_r[7:1] == `ID_ADDR || sh_r[7:1] == `DIAG_ADDR)
                     begin
                        pg_nxt = sh_r[1]; rd_nxt = sh_r[0];
                        first_nxt = 1'b1;
                        drv_nxt = 1'b1; st_nxt = optmod_pkg::I_ACK;
                     end else
                        st_nxt = optmod_pkg::I_IDLE;
                  end else begin
                     if (first_r) off_nxt = sh_r;
                     first_nxt = 1'b0;
                     drv_nxt = 1'b1; st_nxt = optmod_pkg::I_ACK;
                  end
               end
            end
            optmod_pkg::I_ACK: if (fall_w) begin
               if (rd_r) begin
                  sh_nxt = i_rdata; drv_nxt = !i_rdata[7];
                  cnt_nxt = 4'h1; st_nxt = optmod_pkg::I_RD;
                  off_nxt = off_r + 8'h01;
               end else begin
                  drv_nxt = 1'b0; st_nxt = optmod_pkg::I_WR;
               end
            end
            optmod_pkg::I_RD: if (fall_w) begin
               if (cnt_r == 4'h8) begin
                  drv_nxt = 1'b0; cnt_nxt = 4'h9;
               end else if (cnt_r == 4'h9) begin
                  if (sh_r[0]) st_nxt = optmod_pkg::I_IDLE;
                  else begin
                     sh_nxt = i_rdata; drv_nxt = !i_rdata[7];
                     cnt_nxt = 4'h1; off_nxt = off_r + 8'h01;
                  end
               end else begin
                  drv_nxt = !sh_r[6 - cnt_r[2:0] + 3'd1];
                  cnt_nxt = cnt_r + 4'h1;
               end
            end else if (rise_w && cnt_r == 4'h9) begin
               sh_nxt = {7'h00, i_sda};
            end
            default: st_nxt = optmod_pkg::I_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         scl_d_r <= 1'b1; sda_d_r <= 1'b1; st_r <= optmod_pkg::I_IDLE;
         sh_r <= 8'h00; cnt_r <= 4'h0; rd_r <= 1'b0; pg_r <= 1'b0;
         off_r <= 8'h00; drv_r <= 1'b0; first_r <= 1'b0;
      end else begin
         scl_d_r <= i_scl; sda_d_r <= i_sda; st_r <= st_nxt;
         sh_r <= sh_nxt; cnt_r <= cnt_nxt; rd_r <= rd_nxt; pg_r <= pg_nxt;
         off_r <= off_nxt; drv_r <= drv_nxt; first_r <= first_nxt;
      end
   end
   ack_drive_a: assert property (
      @(posedge i_clock) disable iff (i_reset)
      st_r == optmod_pkg::I_ACK |-> !o_sda_oe_n)
      else $error("ack not driven");
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic i_clock,
   // Device data drive, low pulls the line low
   input  wire logic i_sda_oe_n,
   // Serial lines as seen on the board
   output logic      o_scl,
   output logic      o_sda
);
   logic scl_r = 1'b1;
   logic sda_r = 1'b1;
   assign o_scl = scl_r;
   assign o_sda = sda_r & i_sda_oe_n;
   task automatic q(input logic s, input logic d);
      @(posedge i_clock);
      scl_r <= s;
      sda_r <= d;
      repeat (64) @(posedge i_clock);
   endtask
   task automatic bit_io(input logic b, output logic r);
      q(1'b0, b);
      q(1'b1, b);
      #1 r = o_sda;
   endtask
   task automatic start_c();
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      q(1'b1, 1'b0);
      q(1'b0, 1'b0);
   endtask
   task automatic stop_c();
      q(1'b0, 1'b0);
      q(1'b1, 1'b0);
      q(1'b1, 1'b1);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] r, output logic ar);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(a, ar);
   endtask
endmodule

// *** tb/optical_module_control_status_test.sv ***
`timescale 1ns/1ps
`include "optmod_defines.svh"
module optical_module_control_status_test;
   localparam int         ON_T   = 20;
   localparam int         INIT_T = 20;
   localparam logic [7:0] ID_B   = 8'h3c;  // Arbitrary identity value
   logic        i_clock;
   logic        i_reset;
   logic        off_in;
   logic        fault_in;
   logic        lost_in;
   logic [15:0] diag [5];
   logic        scl, sda, sda_out, sda_oe_n, pres, pres_oe_n;
   logic        flt, flt_oe_n, signal_lost_out, los_oe_n, laser, cal_ext;
   int          mismatches;
   int          compares;

   optical_module_control_status #(
      .ON_CNT (ON_T), .INIT_CNT (INIT_T), .ID_BYTE (ID_B)
   ) optical_module_control_status_i (
      .i_clock (i_clock), .i_reset (i_reset),
      .i_transmitter_off_in (off_in), .i_scl (scl), .i_sda (sda),
      .o_sda_out (sda_out), .o_sda_oe_n (sda_oe_n),
      .o_present_out (pres), .o_present_oe_n (pres_oe_n),
      .o_fault_out (flt), .o_fault_oe_n (flt_oe_n),
      .o_signal_lost_out (signal_lost_out), .o_signal_lost_oe_n (los_oe_n),
      .i_laser_fault (fault_in), .i_rx_lost (lost_in),
      .i_temp (diag[0]), .i_vcc (diag[1]), .i_bias (diag[2]),
      .i_txp (diag[3]), .i_rxp (diag[4]),
      .o_laser_on (laser), .o_cal_external (cal_ext)
   );
   host_model host_model_i (
      .i_clock (i_clock), .i_sda_oe_n (sda_oe_n), .o_scl (scl), .o_sda (sda)
   );

   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   // Released open-collector lines read high on the board
   function automatic logic pin(input int w);
      case (w)
         0: return laser;
         1: return flt_oe_n ? 1'b1 : flt;
         default: return los_oe_n ? 1'b1 : signal_lost_out;
      endcase
   endfunction

   function automatic logic [7:0] model(input logic [6:0] dev,
                                        input logic [7:0] off);
      int k;
      k = int'(off - `DIAG_TEMP) / 2;
      if (dev == `DIAG_ADDR) begin
         if (off >= `DIAG_TEMP && off < `DIAG_END)
            return off[0] ? diag[k][7:0] : diag[k][15:8];
         return 8'h00;
      end
      if (off == `CAL_OFF)
         return `CAL_INT_CODE;
      return (off == 8'h00) ? ID_B : 8'h00;
   endfunction

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e);
      chk_byte({7'h00, g}, {7'h00, e});
   endtask

   task automatic await(input int w, input logic v, input int lim);
      #1;
      for (int n = 0; n < lim && pin(w) !== v; n++) begin
         @(posedge i_clock);
         #1;
      end
      chk_bit(pin(w), v);
   endtask

   task automatic rd(input logic [6:0] dev, input logic [7:0] off,
                     input int cnt);
      logic [7:0] qe [$];
      logic [7:0] d;
      logic       a;
      for (int k = 0; k < cnt; k++) begin
         qe.push_back(model(dev, off + 8'(k)));
      end
      host_model_i.start_c();
      host_model_i.xfer({dev, 1'b0}, 1'b1, d, a);
      chk_bit(a, 1'b0);
      host_model_i.xfer(off, 1'b1, d, a);
      chk_bit(a, 1'b0);
      host_model_i.start_c();
      host_model_i.xfer({dev, 1'b1}, 1'b1, d, a);
      chk_bit(a, 1'b0);
      for (int k = 0; k < cnt; k++) begin
         host_model_i.xfer(8'hff, k == cnt - 1, d, a);
         chk_byte(d, qe.pop_front());
      end
      host_model_i.stop_c();
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge i_clock);
      mismatches++;
      summarize();
   end

   initial begin
      logic [7:0] d;
      logic       a;
      void'($urandom(91379));
      mismatches = 0;
      compares = 0;
      i_reset = 1'b1;
      off_in = 1'b1;
      fault_in = 1'b0;
      lost_in = 1'b0;
      foreach (diag[k]) diag[k] = 16'($urandom);
      repeat (20) @(posedge i_clock);
      i_reset <= 1'b0;
      #1 chk_bit(laser, 1'b0);
      chk_bit(pin(1), 1'b0);
      chk_byte({6'h00, pres, pres_oe_n}, 8'h00);
      chk_bit(cal_ext, 1'b0);
      chk_bit(sda_out, 1'b0);
      repeat (INIT_T + ON_T + 10) @(posedge i_clock);
      await(0, 1'b0, 1);
      $display("test init done");
      @(posedge i_clock) off_in <= 1'b0;
      await(0, 1'b1, ON_T + 5);
      @(posedge i_clock) off_in <= 1'b1;
      await(0, 1'b0, `OFF_CYCLES);
      @(posedge i_clock) off_in <= 1'b0;
      await(0, 1'b1, ON_T + 5);
      $display("test shut-off done");
      @(posedge i_clock) fault_in <= 1'b1;
      await(1, 1'b1, `FAULT_CYCLES);
      @(posedge i_clock) fault_in <= 1'b0;
      repeat (10) @(posedge i_clock);
      await(1, 1'b1, 1);
      @(posedge i_clock) off_in <= 1'b1;
      repeat (`RESET_CYCLES + 10) @(posedge i_clock);
      off_in <= 1'b0;
      await(1, 1'b0, 20);
      await(0, 1'b1, ON_T + 5);
      @(posedge i_clock) fault_in <= 1'b1;
      await(1, 1'b1, `FAULT_CYCLES);
      @(posedge i_clock) fault_in <= 1'b0;
      i_reset <= 1'b1;
      @(posedge i_clock) i_reset <= 1'b0;
      await(1, 1'b0, 1);
      await(0, 1'b1, INIT_T + ON_T + 10);
      $display("test fault done");
      for (int k = 0; k < 6; k++) begin
         @(posedge i_clock) lost_in <= ~k[0];
         await(2, ~k[0], `LOSS_CYCLES);
      end
      $display("test signal lost done");
      host_model_i.start_c();
      host_model_i.xfer({7'h52, 1'b0}, 1'b1, d, a);
      chk_bit(a, 1'b1);
      host_model_i.stop_c();
      rd(`ID_ADDR, 8'h00, 1);
      rd(`ID_ADDR, `CAL_OFF, 1);
      for (int k = 0; k < 2; k++) begin
         @(posedge i_clock);
         foreach (diag[j]) diag[j] <= 16'($urandom);
         #1;
         rd(`DIAG_ADDR, `DIAG_TEMP, 10);
      end
      $display("test serial done");
      summarize();
   end
endmodule
